// ===== verilog/rpt_timer.sv
`timescale 1ns/1ps
module rpt_timer
    import rpt_pkg::*;
#(
    parameter int PULSE_LEN = PULSE_CYCLES
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // register port from the serial interface logic
    input wire rpt_wr_t reg_wr_i,
    input wire logic [7:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    // tick sources from oscillator chain and calendar
    input wire logic tick_4k_i,
    input wire logic tick_100hz_i,
    input wire logic tick_sec_i,
    input wire logic tick_min_i,
    input wire logic calendar_run_i,
    // status inputs
    input wire logic alarm_match_flag_i,
    input wire logic battery_mode_i,
    input wire logic second_interrupt_enable_i,
    input wire logic expiry_flag_clear_i,
    // outputs
    output logic expiry_status_flag_o,
    output logic second_interrupt_output_n_o
);
    rpt_control_t ctrl;
    logic [7:0] timer_limit;
    logic [7:0] sub_counter_limit;
    logic [7:0] count;
    logic [7:0] sub_counter;
    logic expired;
    logic irq_low;
    logic armed;
    logic [31:0] pulse_cnt;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic alarm_prev;

    // two-flop sync, then edge detect on the second stage only
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s1 <= 4'h0;
            s2 <= 4'h0;
            s3 <= 4'h0;
        end else begin
            s1 <= {tick_min_i, tick_sec_i, tick_100hz_i, tick_4k_i};
            s2 <= s1;
            s3 <= s2;
        end
    end
    wire [3:0] tick_edge = s2 & ~s3;

    // rate field decoded in two functions, one for the tick pick and one for the default
    function automatic logic pick_tick(input rpt_rate_t rate,
            input logic [3:0] edges, input logic cal_on);
        unique case (rate)
            RATE_4K: pick_tick = edges[0];
            RATE_100HZ: pick_tick = edges[1];
            RATE_SEC: pick_tick = edges[2] & cal_on;
            RATE_MIN: pick_tick = edges[3] & cal_on;
        endcase
    endfunction

    function automatic logic [7:0] pick_default(input rpt_rate_t rate);
        unique case (rate)
            RATE_4K: pick_default = DEF_LIMIT_4K;
            RATE_100HZ: pick_default = DEF_LIMIT_100;
            RATE_SEC, RATE_MIN: pick_default = DEF_LIMIT_60;
        endcase
    endfunction

    // second and minute ticks only count while the calendar runs
    wire calendar_ok = calendar_run_i;
    wire sub_tick;
    wire [7:0] def_limit;
    assign sub_tick = pick_tick(ctrl.tick_rate_select, tick_edge,
        calendar_ok);
    assign def_limit = pick_default(ctrl.tick_rate_select);
    wire [7:0] raw_limit = (sub_counter_limit == 8'h00) ? def_limit :
        sub_counter_limit;
    wire [7:0] wrap_limit = (raw_limit > SUB_MAX) ? SUB_MAX : raw_limit;

    wire is_up = ctrl.count_function_select[1];
    wire [7:0] load_value = is_up ? 8'h01 : timer_limit;
    // enabling write: direction comes from the byte being written
    wire new_up = reg_wr_i.data[BIT_FUNC_HI];
    wire [7:0] start_value = new_up ? 8'h01 : timer_limit;
    wire alarm_rise = alarm_match_flag_i & ~alarm_prev;
    wire gate_ok =
        (ctrl.count_function_select == FN_ALARM_DOWN) ? armed :
        (ctrl.count_function_select == FN_BATT_UP) ? battery_mode_i :
        1'b1;
    wire counting = ctrl.counter_run_bit & gate_ok & ~irq_low &
        ~(expired & ~ctrl.repeat_interrupt_select);
    wire wrap = counting & sub_tick & (sub_counter >= wrap_limit);
    wire [7:0] stepped = is_up ? count + 8'h01 : count - 8'h01;
    wire hit = wrap & (is_up ? (stepped == timer_limit) :
        (stepped == 8'h00));
    wire run_rise = reg_wr_i.wr & (reg_wr_i.addr == ADDR_CONTROL) &
        reg_wr_i.data[BIT_RUN] & ~ctrl.counter_run_bit;
    wire clr_restart = expiry_flag_clear_i & expired;
    wire pulse_done = irq_low & ctrl.repeat_interrupt_select &
        (pulse_cnt >= PULSE_LEN - 1);

    // register writes; count register ignores writes
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctrl <= rpt_control_t'(RESET_BYTE);
            timer_limit <= RESET_BYTE;
            sub_counter_limit <= RESET_BYTE;
        end else if (reg_wr_i.wr) begin
            if (reg_wr_i.addr == ADDR_CONTROL)
                ctrl <= rpt_control_t'(reg_wr_i.data & CONTROL_WMASK);
            if (reg_wr_i.addr == ADDR_LIMIT)
                timer_limit <= reg_wr_i.data;
            if (reg_wr_i.addr == ADDR_SUB_LIMIT)
                sub_counter_limit <= reg_wr_i.data;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            alarm_prev <= 1'b0;
            armed <= 1'b0;
        end else begin
            alarm_prev <= alarm_match_flag_i;
            if (!ctrl.counter_run_bit)
                armed <= 1'b0;
            else if (alarm_rise)
                armed <= 1'b1;
        end
    end

    // main and sub counters
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            count <= RESET_BYTE;
            sub_counter <= SUB_RESET;
        end else if (run_rise) begin
            count <= start_value;
            sub_counter <= SUB_RESET;
        end else if (!ctrl.counter_run_bit) begin
            count <= RESET_BYTE;
            sub_counter <= SUB_RESET;
        end else if (clr_restart || pulse_done) begin
            count <= load_value;
            sub_counter <= SUB_RESET;
        end else if (wrap) begin
            count <= stepped;
            sub_counter <= SUB_RESET;
        end else if (counting && sub_tick) begin
            sub_counter <= sub_counter + 8'h01;
        end
    end

    // expiry flag: set wins over clear
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            expired <= 1'b0;
        end else if (hit) begin
            expired <= 1'b1;
        end else if (expiry_flag_clear_i) begin
            expired <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            irq_low <= 1'b0;
            pulse_cnt <= 32'h0;
        end else if (hit) begin
            irq_low <= 1'b1;
            pulse_cnt <= 32'h0;
        end else if (!ctrl.counter_run_bit || pulse_done) begin
            irq_low <= 1'b0;
        end else if (irq_low && !ctrl.repeat_interrupt_select &&
                expiry_flag_clear_i) begin
            irq_low <= 1'b0;
        end else if (irq_low) begin
            pulse_cnt <= pulse_cnt + 32'h1;
        end
    end

    assign second_interrupt_output_n_o =
        ~(irq_low & second_interrupt_enable_i);
    assign expiry_status_flag_o = expired;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i)
            rd_data_o <= 8'h00;
        else if (rd_addr_i == ADDR_CONTROL)
            rd_data_o <= ctrl;
        else if (rd_addr_i == ADDR_LIMIT)
            rd_data_o <= timer_limit;
        else if (rd_addr_i == ADDR_COUNT)
            rd_data_o <= count;
        else
            rd_data_o <= 8'h00;
    end

    // sub-counter limit is clamped to seven bits in wrap_limit
    sub_bound_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        sub_counter <= SUB_MAX) else $error("sub counter too big");
    stop_clear_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        !ctrl.counter_run_bit && !run_rise |=>
        count == 8'h00 && sub_counter == 8'h01)
        else $error("stop did not clear counters");
    expire_flag_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        hit |=> expired && irq_low) else $error("expiry not flagged");
    irq_gate_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        !second_interrupt_enable_i |-> second_interrupt_output_n_o)
        else $error("pin driven while disabled");
    sub_read_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        rd_addr_i == ADDR_SUB_LIMIT |=> rd_data_o == 8'h00)
        else $error("sub limit readable");
    count_read_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        rd_addr_i == ADDR_COUNT |=> rd_data_o == $past(count))
        else $error("count read wrong");
    step_one_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        wrap && !run_rise && !clr_restart && !pulse_done |=>
        count == ($past(is_up) ? $past(count) + 8'h01 :
        $past(count) - 8'h01))
        else $error("bad main step");
    single_hold_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        irq_low && !ctrl.repeat_interrupt_select && !expiry_flag_clear_i
        && ctrl.counter_run_bit |=> irq_low)
        else $error("single event pin released");
    alarm_wait_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        ctrl.count_function_select == FN_ALARM_DOWN && !armed |-> !wrap)
        else $error("alarm countdown ran early");
    run_load_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        run_rise |=> sub_counter == SUB_RESET &&
        count == ($past(new_up) ? 8'h01 : $past(timer_limit)))
        else $error("enable load wrong");
    sub_step_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        counting && sub_tick && !wrap && !clr_restart && !pulse_done |=>
        sub_counter == $past(sub_counter) + 8'h01)
        else $error("sub counter did not step");
    wrap_reset_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        wrap && !clr_restart |=> sub_counter == SUB_RESET)
        else $error("sub counter not reset on wrap");
    down_dir_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        ctrl.count_function_select == FN_DOWN && wrap && !clr_restart
        |=> count == $past(count) - 8'h01)
        else $error("countdown went wrong way");
    watch_up_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        ctrl.count_function_select == FN_WATCHDOG && wrap && !clr_restart
        |=> count == $past(count) + 8'h01)
        else $error("watchdog went wrong way");
    batt_gate_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        ctrl.count_function_select == FN_BATT_UP && !battery_mode_i
        |-> !wrap) else $error("count up ran off battery");
    flag_clear_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        expiry_flag_clear_i && !hit |=> !expired)
        else $error("expiry flag not cleared");
    expire_hold_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        expired && !expiry_flag_clear_i |=> expired)
        else $error("expiry flag dropped");
    pulse_end_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        pulse_done |=> !irq_low && count == $past(load_value))
        else $error("repeat pulse did not end");
    single_restart_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        clr_restart && ctrl.counter_run_bit &&
        !ctrl.repeat_interrupt_select
        |=> !irq_low && count == $past(load_value))
        else $error("clear did not restart");
    pin_follow_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        second_interrupt_enable_i && irq_low
        |-> !second_interrupt_output_n_o)
        else $error("pin not driven");
    stop_pin_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        !ctrl.counter_run_bit |=> !irq_low)
        else $error("pin held after stop");
    reset_zero_a: assert property (
        @(posedge clk_sys_i)
        rst_i |=> !ctrl.counter_run_bit && !expired && !irq_low)
        else $error("reset state wrong");
    rate_sec_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        ctrl.tick_rate_select == RATE_SEC && !calendar_ok |-> !sub_tick)
        else $error("second tick without calendar");
    rate_min_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        ctrl.tick_rate_select == RATE_MIN && !calendar_ok |-> !sub_tick)
        else $error("minute tick without calendar");
    limit_write_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        reg_wr_i.wr && reg_wr_i.addr == ADDR_LIMIT
        |=> timer_limit == $past(reg_wr_i.data))
        else $error("limit write lost");
    tick_pulse_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (tick_edge & $past(tick_edge)) == 4'h0)
        else $error("tick strobe longer than one cycle");
    armed_clear_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        !ctrl.counter_run_bit |=> !armed)
        else $error("alarm arm kept while stopped");
    alarm_start_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        ctrl.counter_run_bit && alarm_rise |=> armed)
        else $error("alarm edge missed");
    cv_expire: cover property (@(posedge clk_sys_i) disable iff (rst_i) hit);
    cv_restart: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        clr_restart);
    cv_armed: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        alarm_rise && ctrl.count_function_select == FN_ALARM_DOWN);
    cv_pulse: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        pulse_done);
    cv_up: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        wrap && is_up);
endmodule

// ===== verilog/rpt_pkg.sv
// Behaviour
// - select 00: main steps 100 Hz, sub ticks 4 kHz, default limit 41.
// - select 01: main steps 1 s, sub ticks 100 Hz, default limit 100.
// - select 10: main 1 min, sub 1 s, default 60, calendar running.
// - select 11: main 1 hr, sub 1 min, default 60, calendar running.
// - sub limit of zero means use the default for the current select.
// - sub limit never exceeds 127; sub counter never passes 127.
// - sub counter ticks at sub rate; on wrap main steps once.
// - function 00 is a plain countdown on each wrap.
// - function 01 counts down only after the alarm match flag rises.
// - function 10 is a watchdog counting up with periodic interrupts.
// - function 11 counts up only while running on battery.
// - run bit starts timer when one, stops when zero, resets to zero.
// - interrupt pin shows timer events only when its enable is one.
// - repeat select one gives a 210 ms low pulse per event.
// - repeat select zero holds pin low until expiry flag cleared.
// - limit register at 12h, read/write byte, reset zero.
// - register 13h reads the live main count; writes ignored.
// - sub limit register at 14h is written but always reads zero.
// - running sub counter is internal and not visible to software.
// - on enable load main with limit or one, sub with one.
// - on expiry set expiry flag and pull interrupt pin low.
// - clearing run bit sets main count to zero, sub counter to one.
package rpt_pkg;
    localparam logic [7:0] ADDR_CONTROL = 8'h09;
    localparam logic [7:0] ADDR_LIMIT = 8'h12;
    localparam logic [7:0] ADDR_COUNT = 8'h13;
    localparam logic [7:0] ADDR_SUB_LIMIT = 8'h14;
    localparam int BIT_REPEAT = 7;
    localparam int BIT_RUN = 6;
    localparam int BIT_FUNC_HI = 5;
    localparam int BIT_FUNC_LO = 4;
    localparam int BIT_RATE_HI = 1;
    localparam int BIT_RATE_LO = 0;
    localparam logic [7:0] CONTROL_WMASK = 8'hf3;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] SUB_RESET = 8'h01;
    localparam logic [7:0] SUB_MAX = 8'h7f;
    localparam logic [7:0] DEF_LIMIT_4K = 8'h29;
    localparam logic [7:0] DEF_LIMIT_100 = 8'h64;
    localparam logic [7:0] DEF_LIMIT_60 = 8'h3c;
    localparam int PULSE_MS = 210;
    localparam int CLK_MHZ = 125;
    localparam int PULSE_CYCLES = PULSE_MS * 1000 * CLK_MHZ;
    typedef enum logic [1:0] {
        RATE_4K = 2'b00,
        RATE_100HZ = 2'b01,
        RATE_SEC = 2'b10,
        RATE_MIN = 2'b11
    } rpt_rate_t;
    typedef enum logic [1:0] {
        FN_DOWN = 2'b00,
        FN_ALARM_DOWN = 2'b01,
        FN_WATCHDOG = 2'b10,
        FN_BATT_UP = 2'b11
    } rpt_func_t;
    typedef struct packed {
        logic repeat_interrupt_select;
        logic counter_run_bit;
        rpt_func_t count_function_select;
        logic [1:0] zero;
        rpt_rate_t tick_rate_select;
    } rpt_control_t;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } rpt_wr_t;
endpackage

// ===== testbench/rpt_tick_model.sv
`timescale 1ns/1ps
module rpt_tick_model (
    // control from the bench
    input wire logic run_i,
    // tick levels toward the timer
    output logic tick_4k_o,
    output logic tick_100hz_o,
    output logic tick_sec_o,
    output logic tick_min_o
);
    logic wave = 1'b0;
    // one shared 160 ns wave keeps every rate short; offset off the clock edge
    initial begin
        #3;
        forever #80 wave = run_i ? ~wave : 1'b0;
    end
    assign tick_4k_o = wave;
    assign tick_100hz_o = wave;
    assign tick_sec_o = wave;
    assign tick_min_o = wave;
endmodule

// ===== testbench/tb_rpt_timer.sv
`timescale 1ns/1ps
module tb_rpt_timer
    import rpt_pkg::*;
;
    localparam int PLEN = 20;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    rpt_wr_t reg_wr_i = '0;
    logic [7:0] rd_addr_i = 8'h00;
    logic [7:0] rd_data_o;
    logic t4k, t100, tsec, tmin, flag_o, pin_n_o;
    logic cal_i = 1'b1;
    logic alarm_i = 1'b0;
    logic batt_i = 1'b0;
    logic irq_en_i = 1'b1;
    logic clr_i = 1'b0;
    logic tick_run = 1'b0;
    int failures = 0;
    int samples_checked = 0;
    int n;
    int defs[4] = '{41, 100, 60, 60};
    logic [7:0] v;
    always #4 clk_sys_i = ~clk_sys_i;
    rpt_tick_model rpt_tick_model_inst (.run_i(tick_run), .tick_4k_o(t4k),
        .tick_100hz_o(t100), .tick_sec_o(tsec), .tick_min_o(tmin));
    rpt_timer #(.PULSE_LEN(PLEN)) rpt_timer_inst (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .reg_wr_i(reg_wr_i), .rd_addr_i(rd_addr_i),
        .rd_data_o(rd_data_o), .tick_4k_i(t4k), .tick_100hz_i(t100),
        .tick_sec_i(tsec), .tick_min_i(tmin), .calendar_run_i(cal_i),
        .alarm_match_flag_i(alarm_i), .battery_mode_i(batt_i),
        .second_interrupt_enable_i(irq_en_i), .expiry_flag_clear_i(clr_i),
        .expiry_status_flag_o(flag_o), .second_interrupt_output_n_o(pin_n_o));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask
    // strobe dropped, then one idle cycle so a following write is clean
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr_i = '{wr: 1'b1, addr: a, data: d};
        cyc(1);
        reg_wr_i.wr = 1'b0;
        cyc(1);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        rd_addr_i = a;
        cyc(1);
        check(rd_data_o, exp);
    endtask
    task automatic poll(input logic [7:0] exp);
        rd_addr_i = ADDR_COUNT;
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (rd_data_o !== exp && n < 1500);
        check(rd_data_o, exp);
    endtask
    task automatic wflag();
        n = 0;
        while (flag_o !== 1'b1 && n < 2000) begin
            cyc(1);
            n++;
        end
        check({7'h0, flag_o}, 8'h01);
    endtask
    task automatic run(input logic [7:0] c, input logic [7:0] l,
                       input logic [7:0] s);
        wr(ADDR_LIMIT, l);
        wr(ADDR_SUB_LIMIT, s);
        wr(ADDR_CONTROL, c);
    endtask
    task automatic stop();
        wr(ADDR_CONTROL, 8'h00);
        clr_i = 1'b1;
        cyc(1);
        clr_i = 1'b0;
        cyc(1);
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        cyc(60000);
        failures++;
        give_verdict();
    end
    initial begin
        cyc(4);
        rst_i = 1'b0;
        tick_run = 1'b1;
        cyc(1);
        rdchk(ADDR_CONTROL, 8'h00);
        rdchk(ADDR_LIMIT, 8'h00);
        rdchk(ADDR_COUNT, 8'h00);
        check({7'h0, pin_n_o}, 8'h01);
        wr(ADDR_LIMIT, 8'ha5);
        rdchk(ADDR_LIMIT, 8'ha5);
        wr(ADDR_COUNT, 8'h5a);
        rdchk(ADDR_COUNT, 8'h00);
        wr(ADDR_SUB_LIMIT, 8'h7f);
        rdchk(ADDR_SUB_LIMIT, 8'h00);
        rdchk(8'h15, 8'h00);
        wr(ADDR_CONTROL, 8'h8f);
        rdchk(ADDR_CONTROL, 8'h83);
        $display("register test done");
        run(8'h40, 8'h03, 8'h02);
        rdchk(ADDR_COUNT, 8'h03);
        poll(8'h02);
        wflag();
        rdchk(ADDR_COUNT, 8'h00);
        cyc(50);
        check({7'h0, pin_n_o}, 8'h00);
        stop();
        check({7'h0, pin_n_o}, 8'h01);
        rdchk(ADDR_COUNT, 8'h00);
        $display("single countdown test done");
        wr(ADDR_CONTROL, 8'h80);
        run(8'hc0, 8'h03, 8'h02);
        wflag();
        n = 0;
        while (pin_n_o === 1'b0 && n < 100) begin
            cyc(1);
            n++;
        end
        check(n[7:0], PLEN[7:0]);
        stop();
        $display("repeat pulse test done");
        irq_en_i = 1'b0;
        run(8'h50, 8'h02, 8'h02);
        cyc(200);
        rdchk(ADDR_COUNT, 8'h02);
        alarm_i = 1'b1;
        wflag();
        check({7'h0, pin_n_o}, 8'h01);
        stop();
        alarm_i = 1'b0;
        irq_en_i = 1'b1;
        $display("alarm countdown test done");
        run(8'h61, 8'h0a, 8'h02);
        rdchk(ADDR_COUNT, 8'h01);
        poll(8'h03);
        stop();
        run(8'h71, 8'h0a, 8'h02);
        cyc(200);
        rdchk(ADDR_COUNT, 8'h01);
        batt_i = 1'b1;
        poll(8'h03);
        stop();
        batt_i = 1'b0;
        $display("count up tests done");
        for (int r = 0; r < 4; r++) begin
            run(8'h40 | r[7:0], 8'h02, 8'h00);
            cyc((defs[r] - 4) * 20);
            rdchk(ADDR_COUNT, 8'h02);
            poll(8'h01);
            stop();
        end
        $display("default limit test done");
        give_verdict();
    end
endmodule
